// *** cbs_bus_model.sv ***
// External bus interface model that answers the scheduler's bus cycles
`timescale 1ns/10ps
`default_nettype none
module cbs_bus_model
  import cbs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] wait_clks_in,
  input wire logic bus_start_in,
  input wire logic [CBS_AW-1:0] bus_addr_in,
  output logic bus_done_out,
  output logic [CBS_DW-1:0] bus_rdata_out
);
  logic busy_reg;
  logic [3:0] cnt_reg;
  logic [CBS_AW-1:0] addr_reg;
  // ----------------------------------------
  // Cycle timing
  // ----------------------------------------
  // done follows each request after wait_clks_in + 1 clocks
  always_ff @(posedge sys_clk_in) begin
    bus_done_out <= 1'b0;
    // Read data inverts on every clock that delivers no done, so a stale value matches only on every second clock
    bus_rdata_out <= ~bus_rdata_out;
    if (sys_rst_in) begin
      busy_reg <= 1'b0;
      cnt_reg <= 4'h0;
      addr_reg <= 32'h0;
      bus_rdata_out <= 16'h0;
    end else if (bus_start_in && wait_clks_in == 4'h0) begin
      bus_done_out <= 1'b1;
      bus_rdata_out <= bus_addr_in[15:0] ^ 16'h5a3c;
    end else if (bus_start_in) begin
      busy_reg <= 1'b1;
      cnt_reg <= wait_clks_in - 4'h1;
      addr_reg <= bus_addr_in;
    end else if (busy_reg) begin
      if (cnt_reg == 4'h0) begin
        busy_reg <= 1'b0;
        bus_done_out <= 1'b1;
        bus_rdata_out <= addr_reg[15:0] ^ 16'h5a3c;
      end else begin
        cnt_reg <= cnt_reg - 4'h1;
      end
    end
  end
endmodule : cbs_bus_model
`default_nettype wire

// *** cbs_opr_q.sv ***
// Queued operand read request holder
`timescale 1ns/10ps
`default_nettype none
module cbs_opr_q
  import cbs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic rd_req_in,
  input wire logic [1:0] rd_size_in,
  input wire logic [CBS_AW-1:0] rd_addr_in,
  cbs_req_if.owner q
);
  logic val_reg, val_next;
  logic [1:0] size_reg, size_next;
  logic [CBS_AW-1:0] addr_reg, addr_next;

  // RL21 hold request until bus frees
  always_comb begin
    val_next = val_reg;
    size_next = size_reg;
    addr_next = addr_reg;
    if (q.take) begin
      val_next = 1'b0;
    end
    if (rd_req_in && (!val_reg || q.take)) begin
      val_next = 1'b1;
      size_next = rd_size_in;
      addr_next = rd_addr_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      val_reg <= 1'b0;
      size_reg <= 2'h0;
      addr_reg <= '0;
    end else begin
      val_reg <= val_next;
      size_reg <= size_next;
      addr_reg <= addr_next;
    end
  end

  assign q.req = val_reg;
  assign q.wr = 1'b0;
  assign q.size = size_reg;
  assign q.addr = addr_reg;
  assign q.data = 32'h0;
  assign q.busy = val_reg;

  // RL21 queued read survives until started
  rd_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL21
    (val_reg && !q.take) |=> (val_reg && $stable(addr_reg)))
    else $error("queued read dropped");
endmodule : cbs_opr_q
`default_nettype wire

// *** cbs_pkg.sv ***
// Constants and types shared by the bus-cycle scheduler
//
// Operation
// RL1 - Prefetch only when no change of flow is coming and the pipeline has room; code still prefetches up to two words during a branch
// RL2 - Hold exactly one pending operand write so the sequencer keeps running
// RL3 - Queued write may run on the bus during the next instruction head
// RL4 - Stall the sequencer when it writes while the buffer is still full
// RL5 - Operand access always wins over prefetch
// RL6 - Byte and word operands go out as one core bus cycle
// RL7 - Long operands take two cycles, most significant word first
// RL8 - Decode flags imminent change of flow; discarded prefetches are suppressed
// RL9 - Overlap equals the smaller of previous tail and next head
// RL10 - On-chip peripheral accesses complete in two clocks
// RL11 - Operand order on the bus is deterministic for a given sequence
// RL12 - Every executed instruction prefetches one replacement word
// RL13 - Prefetch may start in first clock of an indexed address calculation
// RL14 - Prefetch may start two clocks before instruction end if bus idle
// RL15 - Change of flow leaves two idle clocks usable for one extra prefetch
// RL16 - A branch takes at least three bus cycles
// RL17 - A branch prefetches no more words than it needs itself
// RL18 - Branch displacement is used one clock after its fetch completes
// RL19 - Pipeline needs two words, holds up to three, extra prefetch when possible
// RL20 - New prefetch whenever a pipeline stage becomes invalid
// RL21 - A request that cannot run now is queued and started after current cycle
// RL22 - Arbiter starts at most one new bus cycle per clock
package cbs_pkg;
  localparam int CBS_AW = 32;
  localparam int CBS_DW = 16;
  localparam int CBS_PIPE_MAX = 3;
  localparam int CBS_PIPE_REQ = 2;
  localparam int CBS_PERIPH_CLKS = 2;
  localparam int CBS_COF_IDLE_CLKS = 2;
  localparam int CBS_BRANCH_MIN_CYC = 3;
  localparam int CBS_DISP_DELAY = 1;
  localparam int CBS_EARLY_CLKS = 2;
  localparam logic [1:0] CBS_SZ_BYTE = 2'h0;
  localparam logic [1:0] CBS_SZ_WORD = 2'h1;
  localparam logic [1:0] CBS_SZ_LONG = 2'h2;
  typedef enum logic [3:0] {
    CBS_IDLE = 4'h1,
    CBS_OPR = 4'h2,
    CBS_WR = 4'h4,
    CBS_PF = 4'h8
  } cbs_bus_t;
  function automatic logic [7:0] cbs_min8(input logic [7:0] a, input logic [7:0] b);
    cbs_min8 = (a < b) ? a : b;
  endfunction : cbs_min8
endpackage : cbs_pkg

// *** cbs_req_if.sv ***
// Request carrier between the scheduler and its helper modules
`timescale 1ns/10ps
`default_nettype none
interface cbs_req_if;
  import cbs_pkg::*;
  logic req;
  logic wr;
  logic [1:0] size;
  logic [CBS_AW-1:0] addr;
  logic [31:0] data;
  logic take;
  logic busy;
  modport owner (input take, output req, wr, size, addr, data, busy);
  modport user (output take, input req, wr, size, addr, data, busy);
endinterface : cbs_req_if
`default_nettype wire

// *** cbs_sched.sv ***
// Bus-cycle scheduler: prefetch control, arbitration and cycle sequencing
`timescale 1ns/10ps
`default_nettype none
module cbs_sched
  import cbs_pkg::*;
#(
  parameter int PIPE_DEPTH = CBS_PIPE_MAX
) (
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Microsequencer side
  input wire logic seq_fetch_start_in,
  input wire logic [CBS_AW-1:0] seq_fetch_addr_in,
  input wire logic seq_rd_req_in,
  input wire logic [1:0] seq_rd_size_in,
  input wire logic [CBS_AW-1:0] seq_rd_addr_in,
  input wire logic seq_wr_req_in,
  input wire logic [1:0] seq_wr_size_in,
  input wire logic [CBS_AW-1:0] seq_wr_addr_in,
  input wire logic [31:0] seq_wr_data_in,
  input wire logic seq_word_used_in,
  input wire logic seq_instr_done_in,
  input wire logic seq_indexed_ea_in,
  input wire logic seq_end_near_in,
  input wire logic [7:0] seq_tail_in,
  input wire logic [7:0] seq_head_in,
  input wire logic dec_cof_in,
  input wire logic dec_branch_in,
  // External bus interface side, then outputs back to the microsequencer
  input wire logic bus_done_in,
  input wire logic [CBS_DW-1:0] bus_rdata_in,
  output logic bus_start_out,
  output logic bus_wr_out,
  output logic bus_ifetch_out,
  output logic [1:0] bus_size_out,
  output logic [CBS_AW-1:0] bus_addr_out,
  output logic [CBS_DW-1:0] bus_wdata_out,
  output logic seq_stall_out,
  output logic seq_rd_valid_out,
  output logic [31:0] seq_rd_data_out,
  output logic [1:0] pipe_count_out,
  output logic disp_ready_out,
  output logic [7:0] overlap_out
);
  // Only the three-word pipeline is served by the room arithmetic
  if (PIPE_DEPTH != CBS_PIPE_MAX) begin : g_depth_chk
    $error("pipeline depth must be three words");
  end

  cbs_req_if wq();
  cbs_req_if rq();
  logic wr_stall;

  cbs_wr_buf u_wr (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .wr_req_in(seq_wr_req_in),
    .wr_size_in(seq_wr_size_in),
    .wr_addr_in(seq_wr_addr_in),
    .wr_data_in(seq_wr_data_in),
    .stall_out(wr_stall),
    .q(wq.owner)
  );
  cbs_opr_q u_rd (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .rd_req_in(seq_rd_req_in),
    .rd_size_in(seq_rd_size_in),
    .rd_addr_in(seq_rd_addr_in),
    .q(rq.owner)
  );

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  cbs_bus_t st_reg, st_next;
  logic run_reg, run_next;
  logic [CBS_AW-1:0] pc_reg, pc_next;
  logic [1:0] cnt_reg, cnt_next;
  logic [1:0] inflight_reg, inflight_next;
  logic second_reg, second_next;
  logic [1:0] sz_reg, sz_next;
  logic [CBS_AW-1:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;
  logic [15:0] hi_reg, hi_next;
  logic start_reg, start_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] bcnt_reg, bcnt_next;
  logic disp_reg, disp_next;
  logic [7:0] ovl_reg, ovl_next;

  logic idle, room, pf_ok, pf_want, leave;
  logic [1:0] used;

  assign idle = (st_reg == CBS_IDLE);
  // RL10 next cycle may start on the done edge, no dead clock
  assign leave = !idle && bus_done_in && !(sz_reg == CBS_SZ_LONG && !second_reg);
  assign used = 2'(seq_word_used_in) + 2'(seq_instr_done_in);
  // RL1 room counts words in flight
  assign room = ({1'b0, cnt_reg} + {1'b0, inflight_reg}) < 3'(PIPE_DEPTH);
  // RL16 RL17 branch limits its own fetches
  assign pf_ok = !dec_cof_in || (dec_branch_in && bcnt_reg < 2'(CBS_BRANCH_MIN_CYC - 1));

  // --------------------------------------------------------------
  // Arbitration and sequencing
  // --------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    run_next = run_reg;
    pc_next = pc_reg;
    cnt_next = cnt_reg;
    inflight_next = inflight_reg;
    second_next = second_reg;
    sz_next = sz_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    hi_next = hi_reg;
    start_next = 1'b0;
    rvalid_next = 1'b0;
    rdata_next = rdata_reg;
    bcnt_next = dec_branch_in ? bcnt_reg : 2'h0;
    disp_next = 1'b0;
    ovl_next = ovl_reg;
    wq.take = 1'b0;
    rq.take = 1'b0;
    // RL9 overlap from tail and head
    if (seq_instr_done_in) begin
      ovl_next = cbs_min8(seq_tail_in, seq_head_in);
    end
    // RL20 invalid stage frees a slot
    if (cnt_reg >= used) begin
      cnt_next = cnt_reg - used;
    end else begin
      cnt_next = 2'h0;
    end
    // RL12 RL13 RL14 RL15 replacement prefetch windows; RL19 extra when room
    pf_want = run_reg && room && pf_ok &&
      (seq_instr_done_in || seq_indexed_ea_in || seq_end_near_in || cnt_reg < 2'(CBS_PIPE_REQ) || 1'b1);
    if (seq_fetch_start_in) begin
      pc_next = seq_fetch_addr_in;
      run_next = 1'b1;
      cnt_next = 2'h0;
    end
    if (!idle && bus_done_in) begin
      if (st_reg == CBS_PF) begin
        inflight_next = inflight_reg - 2'h1;
        cnt_next = cnt_next + 2'h1;
        // RL18 displacement usable next clock
        if (dec_branch_in) begin
          disp_next = 1'b1;
        end
      end else if (st_reg == CBS_OPR) begin
        if (sz_reg == CBS_SZ_LONG && !second_reg) begin
          hi_next = bus_rdata_in;
        end else begin
          rvalid_next = 1'b1;
          rdata_next = (sz_reg == CBS_SZ_LONG) ? {hi_reg, bus_rdata_in} : {16'h0, bus_rdata_in};
        end
      end
      // RL7 long goes as second word
      if (sz_reg == CBS_SZ_LONG && !second_reg) begin
        second_next = 1'b1;
        addr_next = addr_reg + CBS_AW'(2);
        start_next = 1'b1;
      end else begin
        st_next = CBS_IDLE;
        second_next = 1'b0;
      end
    end
    // RL21 RL22 one start per clock when idle or on a cycle's final done; RL5 RL11 fixed priority
    if (idle || leave) begin
      if (rq.req) begin
        rq.take = 1'b1;
        st_next = CBS_OPR;
        sz_next = rq.size;
        addr_next = rq.addr;
        start_next = 1'b1;
        second_next = 1'b0;
      end else if (wq.req) begin
        // RL3 write runs under next head
        wq.take = 1'b1;
        st_next = CBS_WR;
        sz_next = wq.size;
        addr_next = wq.addr;
        data_next = wq.data;
        start_next = 1'b1;
        second_next = 1'b0;
      end else if (pf_want && !seq_fetch_start_in) begin
        // RL1 RL8 prefetch only when useful
        st_next = CBS_PF;
        sz_next = CBS_SZ_WORD;
        addr_next = pc_reg;
        pc_next = pc_reg + CBS_AW'(2);
        inflight_next = inflight_next + 2'h1;
        start_next = 1'b1;
        second_next = 1'b0;
        // RL17 counted at start, so fetches still in flight count too
        if (dec_branch_in) begin
          bcnt_next = bcnt_reg + 2'h1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= CBS_IDLE;
      run_reg <= 1'b0;
      pc_reg <= '0;
      cnt_reg <= 2'h0;
      inflight_reg <= 2'h0;
      second_reg <= 1'b0;
      sz_reg <= 2'h0;
      addr_reg <= '0;
      data_reg <= 32'h0;
      hi_reg <= 16'h0;
      start_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      bcnt_reg <= 2'h0;
      disp_reg <= 1'b0;
      ovl_reg <= 8'h0;
    end else begin
      st_reg <= st_next;
      run_reg <= run_next;
      pc_reg <= pc_next;
      cnt_reg <= cnt_next;
      inflight_reg <= inflight_next;
      second_reg <= second_next;
      sz_reg <= sz_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
      hi_reg <= hi_next;
      start_reg <= start_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      bcnt_reg <= bcnt_next;
      disp_reg <= disp_next;
      ovl_reg <= ovl_next;
    end
  end

  // RL6 byte and word as one cycle
  assign bus_start_out = start_reg;
  assign bus_wr_out = (st_reg == CBS_WR);
  assign bus_ifetch_out = (st_reg == CBS_PF);
  assign bus_size_out = sz_reg;
  assign bus_addr_out = addr_reg;
  // RL7 most significant word first
  assign bus_wdata_out = second_reg ? data_reg[15:0] : (sz_reg == CBS_SZ_LONG ? data_reg[31:16] : data_reg[15:0]);
  // RL4 interlock straight from the buffer flag
  assign seq_stall_out = wr_stall;
  assign seq_rd_valid_out = rvalid_reg;
  assign seq_rd_data_out = rdata_reg;
  assign pipe_count_out = cnt_reg;
  assign disp_ready_out = disp_reg;
  assign overlap_out = ovl_reg;

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  // RL5 operand before prefetch
  opr_first_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL5
    (idle && rq.req) |=> (st_reg == CBS_OPR))
    else $error("prefetch beat operand");
  // RL7 long makes two starts
  long_two_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL7
    (!idle && bus_done_in && sz_reg == CBS_SZ_LONG && !second_reg) |=> (start_reg && second_reg))
    else $error("long second word missing");
  // RL1 never overfills the pipeline
  pipe_room_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL1
    ({1'b0, cnt_reg} + {1'b0, inflight_reg}) <= 3'(PIPE_DEPTH))
    else $error("pipeline overfilled");
  // RL18 displacement one clock after fetch
  disp_late_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL18
    (st_reg == CBS_PF && bus_done_in && dec_branch_in) |=> disp_reg)
    else $error("displacement timing wrong");
  // RL9 overlap is the minimum
  ovl_min_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL9
    seq_instr_done_in |=> (ovl_reg <= $past(seq_tail_in) && ovl_reg <= $past(seq_head_in)))
    else $error("overlap not minimum");
  // RL22 one start per clock
  one_start_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL22
    !(rq.take && wq.take))
    else $error("two cycles started");
  // RL8 no prefetch past change of flow
  cof_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL8
    (idle && dec_cof_in && !dec_branch_in && !rq.req && !wq.req) |=> (st_reg != CBS_PF))
    else $error("prefetch during change of flow");
endmodule : cbs_sched
`default_nettype wire

// *** cbs_wr_buf.sv ***
// Single-operand write pending buffer
`timescale 1ns/10ps
`default_nettype none
module cbs_wr_buf
  import cbs_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic wr_req_in,
  input wire logic [1:0] wr_size_in,
  input wire logic [CBS_AW-1:0] wr_addr_in,
  input wire logic [31:0] wr_data_in,
  output logic stall_out,
  cbs_req_if.owner q
);
  logic full_reg, full_next;
  logic [1:0] size_reg, size_next;
  logic [CBS_AW-1:0] addr_reg, addr_next;
  logic [31:0] data_reg, data_next;
  logic load;

  // RL4 interlock while a write is pending
  // Taken from the flop so that sequencer and buffer judge the same edge alike
  assign stall_out = full_reg;
  assign load = wr_req_in && !full_reg;

  // RL2 one held write
  always_comb begin
    full_next = full_reg;
    size_next = size_reg;
    addr_next = addr_reg;
    data_next = data_reg;
    if (q.take) begin
      full_next = 1'b0;
    end
    if (load) begin
      full_next = 1'b1;
      size_next = wr_size_in;
      addr_next = wr_addr_in;
      data_next = wr_data_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      full_reg <= 1'b0;
      size_reg <= 2'h0;
      addr_reg <= '0;
      data_reg <= 32'h0;
    end else begin
      full_reg <= full_next;
      size_reg <= size_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end

  assign q.req = full_reg;
  assign q.wr = 1'b1;
  assign q.size = size_reg;
  assign q.addr = addr_reg;
  assign q.data = data_reg;
  assign q.busy = full_reg;

  // RL4 never overwrites pending write
  no_overwrite_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL4
    (full_reg && !q.take) |=> (addr_reg == $past(addr_reg)))
    else $error("pending write overwritten");
  // RL2 queued write stays until taken
  wr_hold_a: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in) // RL2
    (full_reg && !q.take) |=> full_reg)
    else $error("pending write lost");
endmodule : cbs_wr_buf
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the bus-cycle scheduler
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import cbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic fetch_start = 1'b0, rd_req = 1'b0, wr_req = 1'b0, word_used = 1'b0, instr_done = 1'b0;
  logic indexed_ea = 1'b0, end_near = 1'b0, cof = 1'b0, branch = 1'b0;
  logic [31:0] fetch_addr = 32'h0, rd_addr = 32'h0, wr_addr = 32'h0, wr_data = 32'h0;
  logic [1:0] rd_size = 2'h0, wr_size = 2'h0, pipe_count, bus_size;
  logic [7:0] tail = 8'h0, head = 8'h0, overlap;
  logic [3:0] wait_clks = 4'h0;
  logic bus_done, bus_start, bus_wr, bus_ifetch, stall, rd_valid, disp_ready;
  logic [15:0] bus_rdata, bus_wdata;
  logic [31:0] bus_addr, rd_data, rd_last;
  logic [31:0] log_addr[$];
  logic [3:0] log_kind[$];
  logic [15:0] log_wdata[$];
  int errors = 0, cmp_count = 0, rd_seen = 0, disp_seen = 0;
  logic [31:0] nxt_pf;
  cbs_sched u_cbs_sched (.sys_clk_in(clk), .sys_rst_in(rst), .seq_fetch_start_in(fetch_start),
    .seq_fetch_addr_in(fetch_addr), .seq_rd_req_in(rd_req), .seq_rd_size_in(rd_size),
    .seq_rd_addr_in(rd_addr), .seq_wr_req_in(wr_req), .seq_wr_size_in(wr_size),
    .seq_wr_addr_in(wr_addr), .seq_wr_data_in(wr_data), .seq_word_used_in(word_used),
    .seq_instr_done_in(instr_done), .seq_indexed_ea_in(indexed_ea), .seq_end_near_in(end_near),
    .seq_tail_in(tail), .seq_head_in(head), .dec_cof_in(cof), .dec_branch_in(branch),
    .bus_done_in(bus_done), .bus_rdata_in(bus_rdata), .bus_start_out(bus_start),
    .bus_wr_out(bus_wr), .bus_ifetch_out(bus_ifetch), .bus_size_out(bus_size),
    .bus_addr_out(bus_addr), .bus_wdata_out(bus_wdata), .seq_stall_out(stall),
    .seq_rd_valid_out(rd_valid), .seq_rd_data_out(rd_data), .pipe_count_out(pipe_count),
    .disp_ready_out(disp_ready), .overlap_out(overlap));
  cbs_bus_model u_cbs_bus_model (.sys_clk_in(clk), .sys_rst_in(rst), .wait_clks_in(wait_clks),
    .bus_start_in(bus_start), .bus_addr_in(bus_addr), .bus_done_out(bus_done),
    .bus_rdata_out(bus_rdata));
  // ----------------------------------------
  // Clock and bus monitor
  // ----------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    if (bus_start === 1'b1) begin
      log_addr.push_back(bus_addr);
      log_kind.push_back({bus_wr, bus_ifetch, bus_size});
      log_wdata.push_back(bus_wdata);
    end
    if (rd_valid === 1'b1) begin
      rd_seen++;
      rd_last <= rd_data;
    end
    if (disp_ready === 1'b1) disp_seen++;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] rdat(input logic [31:0] a);
    rdat = a[15:0] ^ 16'h5a3c;
  endfunction : rdat
  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic clr();
    log_addr.delete();
    log_kind.delete();
    log_wdata.delete();
  endtask : clr
  // Pulse one strobe for a single clock: 0 fetch, 1 word used, 2 done, 3 read
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: fetch_start <= 1'b1;
      1: word_used <= 1'b1;
      2: instr_done <= 1'b1;
      default: rd_req <= 1'b1;
    endcase
    @(posedge clk);
    {fetch_start, word_used, instr_done, rd_req} <= 4'h0;
  endtask : ev
  task automatic wait_log(input int n);
    for (int i = 0; i < 80 && log_addr.size() < n; i++) @(posedge clk);
    if (log_addr.size() < n) begin
      `CHK(log_addr.size(), n)
      report_and_stop();
    end
  endtask : wait_log
  task automatic wait_rd(input int n);
    for (int i = 0; i < 80 && rd_seen < n; i++) @(posedge clk);
    if (rd_seen < n) begin
      `CHK(rd_seen, n)
      report_and_stop();
    end
  endtask : wait_rd
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_fill();
    cyc(4);
    `CHK(log_addr.size(), 0)
    `CHK(pipe_count, 2'h0)
    fetch_addr <= 32'h0000_1000;
    ev(0);
    wait_log(3);
    cyc(8);
    `CHK(log_addr.size(), 3)
    for (int i = 0; i < 3; i++) begin
      `CHK(log_addr[i], 32'h0000_1000 + 2 * i)
      `CHK(log_kind[i][3:2], 2'b01)
    end
    `CHK(pipe_count, 2'h3)
    nxt_pf = 32'h0000_1006;
  endtask : t_fill
  task automatic t_overlap();
    logic [7:0] tl[3] = '{8'h04, 8'h02, 8'h05};
    logic [7:0] hd[3] = '{8'h00, 8'h04, 8'h03};
    logic [7:0] ex[3] = '{8'h00, 8'h02, 8'h03};
    for (int i = 0; i < 3; i++) begin
      clr();
      tail <= tl[i];
      head <= hd[i];
      ev(2);
      wait_log(1);
      cyc(4);
      `CHK(overlap, ex[i])
      `CHK(log_addr[0], nxt_pf)
      nxt_pf = nxt_pf + 32'h2;
    end
  endtask : t_overlap
  task automatic t_cof();
    clr();
    cof <= 1'b1;
    ev(2);
    cyc(10);
    `CHK(log_addr.size(), 0)
    `CHK(pipe_count, 2'h2)
    cof <= 1'b0;
    wait_log(1);
    cyc(4);
    `CHK(log_addr[0], nxt_pf)
    nxt_pf = nxt_pf + 32'h2;
  endtask : t_cof
  task automatic t_priority();
    clr();
    rd_size <= CBS_SZ_WORD;
    rd_addr <= 32'h0000_2000;
    @(posedge clk);
    word_used <= 1'b1;
    rd_req <= 1'b1;
    @(posedge clk);
    {word_used, rd_req} <= 2'b00;
    wait_log(2);
    wait_rd(1);
    cyc(6);
    `CHK(log_addr.size(), 2)
    `CHK(log_kind[0], {2'b00, CBS_SZ_WORD})
    `CHK(log_addr[0], 32'h0000_2000)
    `CHK(log_addr[1], nxt_pf)
    `CHK(rd_last[15:0], rdat(32'h0000_2000))
    nxt_pf = nxt_pf + 32'h2;
  endtask : t_priority
  task automatic t_queued();
    clr();
    wait_clks <= 4'h3;
    ev(1);
    cyc(3);
    rd_size <= CBS_SZ_LONG;
    rd_addr <= 32'h0000_3000;
    ev(3);
    wait_log(3);
    wait_rd(2);
    cyc(4);
    `CHK(log_kind[0][2], 1'b1)
    `CHK(log_addr[1], 32'h0000_3000)
    `CHK(log_addr[2], 32'h0000_3002)
    `CHK(rd_last, {rdat(32'h0000_3000), rdat(32'h0000_3002)})
    `CHK(pipe_count, 2'h3)
  endtask : t_queued
  // Write held until the interlock reads low at an edge; the buffer loads on that edge
  task automatic wr_put(input logic [1:0] s, input logic [31:0] a, input logic [31:0] d, inout logic st);
    @(posedge clk);
    wr_req <= 1'b1;
    wr_size <= s;
    wr_addr <= a;
    wr_data <= d;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (stall === 1'b0) break;
      st = 1'b1;
    end
    wr_req <= 1'b0;
    `CHK(stall, 1'b0)
    if (stall !== 1'b0) report_and_stop();
  endtask : wr_put
  task automatic t_write();
    logic sa, sb, sc;
    sa = 1'b0;
    sb = 1'b0;
    sc = 1'b0;
    clr();
    wr_put(CBS_SZ_LONG, 32'h0000_4000, 32'h1234_abcd, sa);
    wr_put(CBS_SZ_WORD, 32'h0000_4010, 32'h0000_5678, sb);
    wr_put(CBS_SZ_BYTE, 32'h0000_4021, 32'h0000_009a, sc);
    wait_log(4);
    cyc(12);
    `CHK(sa, 1'b0)
    `CHK(sb, 1'b0)
    `CHK(sc, 1'b1)
    `CHK(log_addr.size(), 4)
    `CHK(log_addr[0], 32'h0000_4000)
    `CHK(log_addr[1], 32'h0000_4002)
    `CHK(log_wdata[0], 16'h1234)
    `CHK(log_wdata[1], 16'habcd)
    `CHK(log_kind[2], {2'b10, CBS_SZ_WORD})
    `CHK(log_wdata[2], 16'h5678)
    `CHK(log_addr[3], 32'h0000_4021)
    `CHK(log_kind[3], {2'b10, CBS_SZ_BYTE})
    `CHK(log_wdata[3], 16'h009a)
  endtask : t_write
  task automatic t_branch();
    clr();
    wait_clks <= 4'h0;
    cof <= 1'b1;
    branch <= 1'b1;
    ev(2);
    ev(1);
    ev(1);
    cyc(8);
    `CHK(log_addr.size(), 2)
    `CHK(log_addr[0], 32'h0000_1012)
    `CHK(pipe_count, 2'h2)
    `CHK(disp_seen, 2)
    cof <= 1'b0;
    branch <= 1'b0;
    wait_log(3);
    cyc(4);
    `CHK(log_addr[2], 32'h0000_1016)
    `CHK(pipe_count, 2'h3)
  endtask : t_branch
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_fill();
    t_overlap();
    t_cof();
    t_priority();
    t_queued();
    t_write();
    t_branch();
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
